// ===== acq_sel_pkg.sv
// constants, register map and types for the acquisition hit selector
package acq_sel_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CMD1      = 8'h00;
    localparam logic [7:0] OFS_CMD2      = 8'h04;
    localparam logic [7:0] OFS_CMD7      = 8'h08;
    localparam logic [7:0] OFS_AZCOMP    = 8'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_SEL_RANGE = 8'h14;
    localparam logic [7:0] OFS_SEL_INFO  = 8'h18;
    localparam logic [7:0] OFS_AZSUM     = 8'h1C;
    localparam logic [7:0] OFS_WORD18    = 8'h20;
    localparam logic [7:0] OFS_AMB_BASE  = 8'h40;
    // command word 1 fields
    localparam int CMD1_NARROW_BIT = 0;
    localparam int CMD1_GATED_BIT  = 1;
    localparam int CMD1_BARKER_BIT = 2;
    localparam int CMD1_APPLY_BIT  = 3;
    // command word 2 fields: coarse/unambiguous low half, ambiguous high
    localparam int RANGE_W   = 16;
    localparam int AMB_LSB   = 16;
    // gate geometry
    localparam int GATE_BINS    = 7;
    localparam int GATE_FILTERS = 11;
    localparam int HM_BINS      = 64;
    localparam int AMB_WORD0    = 7;
    localparam int RES_WORD     = 18;
    localparam int AZ_GATE_DEG  = 3;
    localparam int AZ_W         = 16;
    // azimuth units per degree of the azimuth word
    localparam int AZ_PER_DEG   = 64;
    localparam logic [AZ_W-1:0] AZ_GATE = 16'(AZ_GATE_DEG * AZ_PER_DEG);
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // prf type code carried with the selected target
    typedef enum logic [2:0] {
        PRF_HI_MINOR, PRF_MAJOR, PRF_LO_MINOR,
        PW_1US, PW_1P3US, PW_1P6US
    } prf_class_type;

    typedef enum logic [1:0] {
        ST_IDLE, ST_NARROW, ST_GATED
    } mode_type;
endpackage : acq_sel_pkg

// ===== acq_hit_selector.sv
// medium prf acquisition hit selector with axi4-lite registers
`timescale 1ns/1ps
module acq_hit_selector
    import acq_sel_pkg::*;
#(
    parameter int AMP_W = 16
) (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // axi4-lite slave
    input  wire logic [7:0]            s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [7:0]            s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // live hit stream, one range cell per strobe
    input  wire logic                  hit_strobe,
    input  wire logic [acq_sel_pkg::RANGE_W-1:0] hit_range,
    input  wire logic [5:0]            hit_bin,
    input  wire logic [3:0]            hit_filter,
    input  wire logic [AMP_W-1:0]      hit_amplitude,
    input  wire logic [AMP_W-1:0]      cfar_threshold,
    input  wire logic                  hit_barker,
    input  wire logic                  hit_major_group,
    input  wire logic                  hit_hi_minor,
    input  wire logic                  hit_stored,
    input  wire logic [acq_sel_pkg::AZ_W-1:0] hit_azimuth,
    input  wire logic [2:0]            hit_elev_bar,
    input  wire acq_sel_pkg::prf_class_type hit_prf_class,
    input  wire logic                  interval_end,
    input  wire logic [acq_sel_pkg::AZ_W-1:0] commanded_azimuth,
    // outputs to other units
    output logic                       scan_converter_inhibit,
    output logic                       clutter_accum_enable,
    output logic                       array_valid_tag,
    output logic                       target_valid,
    output logic                       azimuth_apply,
    output logic [acq_sel_pkg::AZ_W-1:0] azimuth_apply_sum
);
    import acq_sel_pkg::*;

    typedef struct packed {
        logic        awready, wready, bvalid, arready, rvalid;
        logic [1:0]  bresp, rresp;
        logic [31:0] rdata;
        logic        aw_got, w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic [31:0] cmd1, cmd2, cmd7;
        logic [AZ_W-1:0] az_sum;
        logic        apply;
        logic [AZ_W-1:0] apply_sum;
        logic        inhibit, cde_en, tag, tvalid;
        logic        cand_found;
        logic [RANGE_W-1:0] cand_range;
        logic [AZ_W-1:0] cand_az;
        logic [2:0]  cand_elev;
        prf_class_type cand_prf;
        logic [RANGE_W-1:0] sel_range;
        logic [AZ_W-1:0] sel_az;
        logic [2:0]  sel_elev;
        prf_class_type sel_prf;
        logic [GATE_BINS-1:0] res_acc, res_word;
        logic [GATE_FILTERS*GATE_BINS-1:0] amb_acc, amb_word;
        logic        amb_seen;
    } state_type;

    state_type s_r, s_nxt;

    // absolute azimuth difference
    function automatic logic [AZ_W-1:0] az_diff(
        input logic [AZ_W-1:0] a, input logic [AZ_W-1:0] b);
        az_diff = (a >= b) ? a - b : b - a;
    endfunction : az_diff

    function automatic logic [31:0] apply_wr(
        input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (st[k]) begin
                r[k*8 +: 8] = d[k*8 +: 8];
            end
        end
        apply_wr = r;
    endfunction : apply_wr

    mode_type mode;
    logic [RANGE_W-1:0] coarse_rng, amb_rng, rel_res, rel_amb;
    logic over_thr, res_in, amb_in;
    logic [2:0] res_idx, amb_bin;
    logic [3:0] amb_idx;

    always_comb begin
        logic [7:0] ra;
        logic [31:0] rd;
        logic [3:0]  fi;
        state_type n;
        ra = 8'h00;
        rd = RESET_WORD;
        fi = 4'h0;
        n = s_r;
        mode = s_r.cmd1[CMD1_NARROW_BIT] ? ST_NARROW :
               (s_r.cmd1[CMD1_GATED_BIT] ? ST_GATED : ST_IDLE);
        coarse_rng = s_r.cmd2[RANGE_W-1:0];
        amb_rng = s_r.cmd2[AMB_LSB +: RANGE_W];
        over_thr = hit_amplitude > cfar_threshold;
        rel_res = hit_range - coarse_rng;
        rel_amb = RANGE_W'(hit_bin) - amb_rng;
        // major prf bin units keep the gate at the assigned bin width
        res_in = hit_major_group && hit_range >= coarse_rng
                 && rel_res < RANGE_W'(GATE_BINS);
        res_idx = rel_res[2:0];
        amb_in = hit_hi_minor && RANGE_W'(hit_bin) >= amb_rng
                 && rel_amb < RANGE_W'(GATE_BINS)
                 && hit_filter < 4'(GATE_FILTERS);
        amb_bin = rel_amb[2:0];
        amb_idx = hit_filter;

        // axi write path
        if (s_r.awready && s_axi_awvalid) begin
            n.awready = 1'b0;
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s_r.wready && s_axi_wvalid) begin
            n.wready = 1'b0;
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        n.apply = 1'b0;
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
            n.bvalid = 1'b1;
            n.bresp = 2'b00;
            case (s_r.awaddr)
                OFS_CMD1: n.cmd1 = apply_wr(s_r.cmd1, s_r.wdata, s_r.wstrb);
                OFS_CMD2: n.cmd2 = apply_wr(s_r.cmd2, s_r.wdata, s_r.wstrb);
                OFS_CMD7: n.cmd7 = apply_wr(s_r.cmd7, s_r.wdata, s_r.wstrb);
                OFS_AZCOMP: n.az_sum = AZ_W'(s_r.az_sum
                                             + s_r.wdata[AZ_W-1:0]);
                default: n.bresp = 2'b10;
            endcase
        end
        if (s_r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end

        // apply command: hand sum to target store and clear it
        if (n.cmd1[CMD1_APPLY_BIT]) begin
            n.apply = 1'b1;
            n.apply_sum = n.az_sum;
            n.az_sum = '0;
            n.cmd1[CMD1_APPLY_BIT] = 1'b0;
        end

        // axi read path
        if (s_r.arready && s_axi_arvalid) begin
            ra = s_axi_araddr;
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = 2'b00;
            fi = 4'((ra - OFS_AMB_BASE) >> 2);
            case (ra)
                OFS_CMD1: rd = s_r.cmd1;
                OFS_CMD2: rd = s_r.cmd2;
                OFS_CMD7: rd = s_r.cmd7;
                OFS_AZCOMP: rd = RESET_WORD;
                OFS_STATUS: rd = {27'h000_0000, s_r.cde_en, s_r.inhibit,
                                  s_r.tag, s_r.tvalid, s_r.cand_found};
                OFS_SEL_RANGE: rd = {16'h0000, s_r.sel_range};
                OFS_SEL_INFO: rd = {10'h000, s_r.sel_prf, s_r.sel_elev,
                                    s_r.sel_az};
                OFS_AZSUM: rd = {16'h0000, s_r.az_sum};
                OFS_WORD18: rd = {25'h000_0000, s_r.res_word};
                default: begin
                    // full-width bound: a 4-bit index alone would alias
                    if (ra >= OFS_AMB_BASE && ra[1:0] == 2'b00
                        && ra < 8'(OFS_AMB_BASE + 4 * GATE_FILTERS)) begin
                        rd = {25'h000_0000,
                              s_r.amb_word[fi*GATE_BINS +: GATE_BINS]};
                    end else begin
                        n.rresp = 2'b10;
                    end
                end
            endcase
            n.rdata = rd;
        end
        if (s_r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        // mode side outputs
        n.inhibit = (mode == ST_GATED);
        n.cde_en = (mode != ST_NARROW);

        // hit selection
        if (hit_strobe && over_thr) begin
            case (mode)
                ST_NARROW: begin
                    if (hit_range > coarse_rng
                        && (!hit_stored
                            || az_diff(hit_azimuth, commanded_azimuth)
                               <= AZ_GATE)
                        && (!s_r.cand_found
                            || hit_range < s_r.cand_range)) begin
                        n.cand_found = 1'b1;
                        n.cand_range = hit_range;
                        n.cand_az = hit_azimuth;
                        n.cand_elev = hit_elev_bar;
                        n.cand_prf = hit_prf_class;
                    end
                end
                ST_GATED: begin
                    if (hit_barker == s_r.cmd1[CMD1_BARKER_BIT]) begin
                        if (res_in) begin
                            n.res_acc[res_idx] = 1'b1;
                        end
                        if (amb_in) begin
                            n.amb_acc[amb_idx*GATE_BINS + amb_bin] = 1'b1;
                            n.amb_seen = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end

        // end of interval: publish results and restart gathering
        if (interval_end) begin
            n.tvalid = (mode == ST_NARROW) && s_r.cand_found;
            n.sel_range = s_r.cand_found ? s_r.cand_range : '0;
            n.sel_az = s_r.cand_az;
            n.sel_elev = s_r.cand_elev;
            n.sel_prf = s_r.cand_prf;
            n.res_word = s_r.res_acc;
            n.amb_word = s_r.amb_acc;
            n.tag = (mode == ST_GATED) && s_r.amb_seen;
            n.cand_found = 1'b0;
            n.res_acc = '0;
            n.amb_acc = '0;
            n.amb_seen = 1'b0;
        end
        s_nxt = n;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_r <= '0;
            s_r.awready <= 1'b1;
            s_r.wready <= 1'b1;
            s_r.arready <= 1'b1;
            s_r.cde_en <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready = s_r.awready;
    assign s_axi_wready = s_r.wready;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arready;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rresp = s_r.rresp;
    assign s_axi_rdata = s_r.rdata;
    assign scan_converter_inhibit = s_r.inhibit;
    assign clutter_accum_enable = s_r.cde_en;
    assign array_valid_tag = s_r.tag;
    assign target_valid = s_r.tvalid;
    assign azimuth_apply = s_r.apply;
    assign azimuth_apply_sum = s_r.apply_sum;

    AST_INHIBIT: assert property (@(posedge clk_sys) disable iff (reset)
        s_r.cmd1[CMD1_GATED_BIT] && !s_r.cmd1[CMD1_NARROW_BIT]
        |=> scan_converter_inhibit)
        else $error("inhibit not raised in gated mode");
    AST_NO_CDE: assert property (@(posedge clk_sys) disable iff (reset)
        s_r.cmd1[CMD1_NARROW_BIT] |=> !clutter_accum_enable)
        else $error("clutter accumulation during narrow mode");
    AST_TAG: assert property (@(posedge clk_sys) disable iff (reset)
        interval_end && !s_r.amb_seen |=> !array_valid_tag)
        else $error("tag set without array data");
    AST_NOHIT: assert property (@(posedge clk_sys) disable iff (reset)
        interval_end && !s_r.cand_found |=> !target_valid)
        else $error("target valid without a hit");
    AST_CLOSEST: assert property (@(posedge clk_sys) disable iff (reset)
        interval_end && s_r.cand_found |=>
        target_valid == s_r.cmd1[CMD1_NARROW_BIT]
        && s_r.sel_range > coarse_rng)
        else $error("selected range not beyond coarse range");
    AST_SHORTEST: assert property (@(posedge clk_sys) disable iff (reset)
        s_r.cand_found && !interval_end |=>
        s_r.cand_range <= $past(s_r.cand_range))
        else $error("candidate range grew");
    AST_THRESH: assert property (@(posedge clk_sys) disable iff (reset)
        hit_strobe && !over_thr && !interval_end |=>
        $stable(s_r.cand_range) && $stable(s_r.res_acc))
        else $error("sub-threshold hit accepted");
    AST_APPLY: assert property (@(posedge clk_sys) disable iff (reset)
        azimuth_apply |-> s_r.az_sum == '0
        && azimuth_apply_sum == $past(s_r.az_sum))
        else $error("azimuth sum not handed over and cleared");
    AST_APPLY_ONE: assert property (@(posedge clk_sys) disable iff (reset)
        azimuth_apply |=> !azimuth_apply)
        else $error("apply pulse longer than one cycle");
endmodule : acq_hit_selector

// ===== acq_rdp_model.sv
// axi4-lite master standing in for the radar data processor
`timescale 1ns/1ps
module acq_rdp_model (
    // clock
    input  wire logic        clk_sys,
    // axi4-lite master
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
        s_axi_wstrb = 4'h0;
    end

    task automatic write_word(input logic [7:0] a, input logic [31:0] d,
                              output logic [1:0] r);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
                // released payload shows a changed value
                s_axi_awaddr <= ~a;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (!(aw_done && w_done));
        while (!s_axi_bvalid) @(posedge clk_sys);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : write_word

    task automatic read_word(input logic [7:0] a, output logic [31:0] d,
                             output logic [1:0] r);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk_sys); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr <= ~a;
        while (!s_axi_rvalid) @(posedge clk_sys);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : read_word
endmodule : acq_rdp_model

// ===== tb_medium_prf_acquisition_hit_selector.sv
// self-checking bench for the acquisition hit selector
`timescale 1ns/1ps
module tb_medium_prf_acquisition_hit_selector;
    import acq_sel_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic hit_strobe = 0, hit_barker = 0, hit_major_group = 0;
    logic hit_hi_minor = 0, hit_stored = 0, interval_end = 0;
    logic [15:0] hit_range = 0, hit_amplitude = 0, hit_azimuth = 0;
    logic [15:0] cfar_threshold = 16'h0100, commanded_azimuth = 16'h1000;
    logic [5:0] hit_bin = 0;
    logic [3:0] hit_filter = 0;
    logic [2:0] hit_elev_bar = 0;
    prf_class_type hit_prf_class = PRF_HI_MINOR;
    logic scan_converter_inhibit, clutter_accum_enable, array_valid_tag;
    logic target_valid, azimuth_apply;
    logic [15:0] azimuth_apply_sum, got_sum;
    logic [31:0] seed = 32'd93457;
    int n_errors = 0, n_checks = 0, n_apply = 0;

    always #20 clk_sys = ~clk_sys;

    acq_hit_selector #(.AMP_W(16)) acq_hit_selector_inst (.clk_sys, .reset,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .hit_strobe, .hit_range, .hit_bin, .hit_filter,
        .hit_amplitude, .cfar_threshold, .hit_barker, .hit_major_group,
        .hit_hi_minor, .hit_stored, .hit_azimuth, .hit_elev_bar,
        .hit_prf_class, .interval_end, .commanded_azimuth,
        .scan_converter_inhibit, .clutter_accum_enable, .array_valid_tag,
        .target_valid, .azimuth_apply, .azimuth_apply_sum);

    acq_rdp_model acq_rdp_model_inst (.clk_sys, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    // the apply pulse may come and go while the write answer is pending
    always @(posedge clk_sys) begin
        if (azimuth_apply === 1'b1) begin
            n_apply <= n_apply + 1;
            got_sum <= azimuth_apply_sum;
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: flag %h expected %h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        acq_rdp_model_inst.write_word(a, d, r);
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        acq_rdp_model_inst.read_word(a, d, r);
        chk_word(d, exp);
    endtask : rdchk

    // one hit cell; k packs {barker, hi_minor, major, stored}
    task automatic send(input logic [15:0] r, input logic [15:0] amp,
                        input logic [3:0] k, input logic [15:0] az,
                        input logic [9:0] bf);
        @(posedge clk_sys);
        hit_strobe <= 1'b1;
        hit_range <= r;
        hit_amplitude <= amp;
        {hit_barker, hit_hi_minor, hit_major_group, hit_stored} <= k;
        hit_azimuth <= az;
        {hit_bin, hit_filter} <= bf;
        @(posedge clk_sys);
        hit_strobe <= 1'b0;
    endtask : send

    task automatic publish();
        @(posedge clk_sys);
        interval_end <= 1'b1;
        @(posedge clk_sys);
        interval_end <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : publish

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    initial begin
        #400_000;
        n_errors++;
        $display("watchdog expired");
        close_out();
    end

    initial begin : main
        logic [31:0] d;
        logic [1:0] rs;
        logic [31:0] exp18;
        logic [31:0] expamb [11];
        logic [15:0] az;
        int i;
        int j;
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        rdchk(OFS_STATUS, 32'h0000_0010);
        acq_rdp_model_inst.read_word(8'h3C, d, rs);
        chk_word(32'(rs), 32'h0000_0002);
        $display("test reset done");
        wr(OFS_CMD2, 32'h0000_0064);
        wr(OFS_CMD1, 32'h0000_0001);
        repeat (2) @(posedge clk_sys);
        #1 chk_flag(clutter_accum_enable, 1'b0);
        for (int c = 0; c < 6; c++) begin
            seed = lfsr_next(seed);
            az = seed[15:0];
            hit_prf_class <= prf_class_type'(c);
            hit_elev_bar <= 3'(c);
            send(16'd101, 16'h0200, 4'b0001, 16'h10C1, 10'h0);
            send(16'd100, 16'h0200, 4'b0000, 16'h0, 10'h0);
            send(16'd102, 16'h0100, 4'b0000, 16'h0, 10'h0);
            send(16'(103 + c), 16'h0101, 4'b0000, az, 10'h0);
            send(16'd110, 16'h0200, 4'b0001, 16'h0F40, 10'h0);
            send(16'(300 + seed[23:16]), 16'h0300, 4'b0, ~az, 10'h0);
            publish();
            chk_flag(target_valid, 1'b1);
            rdchk(OFS_SEL_RANGE, 32'(103 + c));
            rdchk(OFS_SEL_INFO, (c << 19) | (c << 16) | az);
        end
        publish();
        chk_flag(target_valid, 1'b0);
        $display("test narrow done");
        wr(OFS_CMD2, 32'h000A_00C8);
        wr(OFS_CMD7, lfsr_next(seed));
        wr(OFS_CMD1, 32'h0000_0002);
        repeat (2) @(posedge clk_sys);
        #1 chk_flag(scan_converter_inhibit, 1'b1);
        exp18 = 32'h0000_0041;
        expamb = '{default: 32'h0};
        send(16'd200, 16'h0200, 4'b0010, 16'h0, 10'h0);
        send(16'd206, 16'h0200, 4'b0010, 16'h0, 10'h0);
        send(16'd207, 16'h0200, 4'b0010, 16'h0, 10'h0);
        send(16'd199, 16'h0200, 4'b0010, 16'h0, 10'h0);
        send(16'd203, 16'h0200, 4'b1010, 16'h0, 10'h0);
        send(16'd204, 16'h0200, 4'b0000, 16'h0, 10'h0);
        send(16'd205, 16'h0100, 4'b0010, 16'h0, 10'h0);
        send(16'd0, 16'h0200, 4'b0100, 16'h0, {6'd9, 4'd0});
        for (int n = 0; n < 16; n++) begin
            seed = lfsr_next(seed);
            send(16'(200 + seed % 3), 16'h0200, 4'b0010, 16'h0, 10'h0);
            exp18 = exp18 | (32'h1 << (seed % 3));
            i = seed[11:8] % 12;
            j = seed[14:12];
            send(16'd0, 16'h0200, 4'b0100, 16'h0, {6'(10 + j), 4'(i)});
            if (i < 11 && j < 7) expamb[i] = expamb[i] | (32'h1 << j);
        end
        publish();
        chk_flag(array_valid_tag, 1'b1);
        rdchk(OFS_WORD18, exp18);
        for (int f = 0; f < 11; f++)
            rdchk(OFS_AMB_BASE + 8'(4 * f), expamb[f]);
        wr(OFS_CMD1, 32'h0000_0006);
        send(16'd203, 16'h0200, 4'b1010, 16'h0, 10'h0);
        send(16'd204, 16'h0200, 4'b0010, 16'h0, 10'h0);
        publish();
        chk_flag(array_valid_tag, 1'b0);
        rdchk(OFS_WORD18, 32'h0000_0008);
        $display("test gated done");
        seed = lfsr_next(seed);
        wr(OFS_AZCOMP, {24'h0, seed[7:0]});
        wr(OFS_AZCOMP, {24'h0, seed[15:8]});
        rdchk(OFS_AZSUM, 32'(seed[7:0]) + 32'(seed[15:8]));
        wr(OFS_CMD1, 32'h0000_0008);
        repeat (3) @(posedge clk_sys);
        #1 chk_word(32'(n_apply), 32'h0000_0001);
        chk_word(32'(got_sum), 32'(seed[7:0]) + 32'(seed[15:8]));
        chk_flag(scan_converter_inhibit, 1'b0);
        rdchk(OFS_AZSUM, 32'h0000_0000);
        $display("test azimuth done");
        close_out();
    end
endmodule : tb_medium_prf_acquisition_hit_selector
